// ### rtl/plon_notifier.sv
`timescale 1ns/1ps
`default_nettype none
`include "plon_defines.svh"
module plon_notifier
  import plon_pkg::*;
#(
  parameter int PWR_TMO_CYC = `PLON_PWR_TMO_CYC,
  parameter int TX_W = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link side pins.
  input wire logic link_power_status_in,
  input wire logic link_on_pkt_in,
  input wire logic bus_reset_in,
  input wire logic power_cycled_in,
  output logic phy_status_serial_out,
  output logic link_wake_notify_out,
  output logic link_wake_notify_oe_n,
  // Interrupt.
  output logic irq
);
  localparam int CNT_W = $clog2(TX_W + 1);
  logic lpwr_s1_ff, lpwr_s2_ff;
  logic pkt_s1_ff, pkt_s2_ff, pkt_d_ff;
  logic brst_s1_ff, brst_s2_ff, brst_d_ff;
  logic pwr_s1_ff, pwr_s2_ff, pwr_d_ff;
  plon_ctrl_t ctrl_ff, nxt_ctrl;
  plon_cause_t cause_ff, nxt_cause;
  logic [2:0] wave_cnt_ff, nxt_wave_cnt;
  logic [31:0] pwr_cnt_ff, nxt_pwr_cnt;
  logic wake_ff, nxt_wake, oe_n_ff, nxt_oe_n;
  logic [2:0] ist_ff, nxt_ist, mask_ff, nxt_mask;
  logic irq_ff, nxt_irq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  plon_tx_state_t tx_st_ff, nxt_tx_st;
  logic [TX_W-1:0] tx_sh_ff, nxt_tx_sh;
  logic [$clog2(TX_W+1)-1:0] tx_cnt_ff, nxt_tx_cnt;
  logic ser_ff, nxt_ser;
  logic link_active, any_cause, flag_cond, pwr_rise, pkt_rise, brst_rise;
  logic wr, rd, tx_done, pwr_expire;

  // Pin inputs pass two flip-flops.
  always_ff @(posedge sys_clk) begin
    lpwr_s1_ff <= link_power_status_in;
    lpwr_s2_ff <= lpwr_s1_ff;
    pkt_s1_ff <= link_on_pkt_in;
    pkt_s2_ff <= pkt_s1_ff;
    pkt_d_ff <= pkt_s2_ff;
    brst_s1_ff <= bus_reset_in;
    brst_s2_ff <= brst_s1_ff;
    brst_d_ff <= brst_s2_ff;
    pwr_s1_ff <= power_cycled_in;
    pwr_s2_ff <= pwr_s1_ff;
    pwr_d_ff <= pwr_s2_ff;
  end

  assign pkt_rise = pkt_s2_ff & ~pkt_d_ff;
  assign brst_rise = brst_s2_ff & ~brst_d_ff;
  assign pwr_rise = pwr_s2_ff & ~pwr_d_ff;
  assign link_active = lpwr_s2_ff & ctrl_ff.link_control_bit; // [R10]
  assign flag_cond = ctrl_ff.port_event_flag | // [R7]
    (ctrl_ff.resume_port_irq_enable & (ctrl_ff.config_timeout_flag |
    ctrl_ff.cable_power_change_flag | ctrl_ff.state_timeout_flag)); // [R8]
  assign pwr_expire = cause_ff.pwr && pwr_cnt_ff == 32'(PWR_TMO_CYC - 1);
  // Writes land at the first access edge, the same edge that raises pready.
  assign wr = psel & penable & pwrite & ~pready_ff;
  assign rd = psel & penable & ~pwrite & ~pready_ff;
  assign any_cause = |cause_ff;

  // Wake cause tracking.
  always_comb begin
    nxt_cause = cause_ff;
    nxt_pwr_cnt = pwr_cnt_ff;
    if (link_active) begin
      nxt_cause = '0; // [R10]
    end else begin
      nxt_cause.flag = flag_cond; // [R5] [R7] [R8] [R13]
      if (pkt_rise) begin
        nxt_cause.pkt = 1'b1; // [R6]
      end else if (brst_rise) begin
        nxt_cause.pkt = 1'b0; // [R11]
      end
      // The power-cycle timer runs only while its cause stands.
      if (pwr_rise && ctrl_ff.pclass <= `PLON_MAX_PCLASS) begin
        nxt_cause.pwr = 1'b1; // [R9]
        nxt_pwr_cnt = '0;
      end else if (pwr_expire) begin
        nxt_cause.pwr = 1'b0; // [R12]
      end else if (cause_ff.pwr) begin
        nxt_pwr_cnt = pwr_cnt_ff + 32'd1;
      end
    end
  end

  // Square wave output.
  always_comb begin
    nxt_oe_n = 1'b0; // [R2]
    nxt_wave_cnt = any_cause ? wave_cnt_ff + 3'd1 : 3'd0;
    // The phase comes from the count before it advances, so the first
    // high phase after activation is as long as every later one.
    nxt_wake = any_cause &
      (wave_cnt_ff < 3'(`PLON_WAVE_HALF)); // [R3] [R14]
    if (!any_cause) begin
      nxt_wake = 1'b0; // [R4]
    end
  end

  // Serial status shifter.
  assign tx_done = (tx_st_ff == PLON_TX_SHIFT) && tx_cnt_ff == '0;
  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_ser = 1'b0;
    case (tx_st_ff)
      PLON_TX_IDLE: begin
        if (wr && paddr == `PLON_TX_OFS) begin
          nxt_tx_sh = pwdata[TX_W-1:0];
          nxt_tx_cnt = CNT_W'(TX_W);
          nxt_tx_st = PLON_TX_SHIFT;
        end
      end
      PLON_TX_SHIFT: begin
        if (tx_cnt_ff == '0) begin
          nxt_tx_st = PLON_TX_IDLE;
        end else begin
          nxt_ser = tx_sh_ff[TX_W-1]; // [R1]
          nxt_tx_sh = {tx_sh_ff[TX_W-2:0], 1'b0};
          nxt_tx_cnt = tx_cnt_ff - 1'b1;
        end
      end
      default: nxt_tx_st = PLON_TX_IDLE;
    endcase
  end

  // APB registers and interrupts.
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = psel & penable & ~pready_ff;
    nxt_pslverr = 1'b0;
    nxt_ist = ist_ff;
    if (wr) begin
      case (paddr)
        `PLON_CTRL_OFS: begin
          nxt_ctrl.link_control_bit = pwdata[`PLON_CTRL_LINK_CTL];
          nxt_ctrl.port_event_flag = pwdata[`PLON_CTRL_PORT_EVT];
          nxt_ctrl.config_timeout_flag = pwdata[`PLON_CTRL_CFG_TMO];
          nxt_ctrl.cable_power_change_flag = pwdata[`PLON_CTRL_CBL_PWR];
          nxt_ctrl.state_timeout_flag = pwdata[`PLON_CTRL_STATE_TMO];
          nxt_ctrl.resume_port_irq_enable = pwdata[`PLON_CTRL_RESUME_EN];
          nxt_ctrl.pclass = pwdata[`PLON_CTRL_PCLS +: 3];
        end
        `PLON_IRQ_STAT_OFS: nxt_ist = ist_ff & ~pwdata[2:0];
        `PLON_IRQ_MASK_OFS: nxt_mask = pwdata[2:0];
        `PLON_TX_OFS: nxt_pslverr = tx_st_ff != PLON_TX_IDLE;
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (rd) begin
      case (paddr)
        `PLON_CTRL_OFS: nxt_prdata = {21'h0, ctrl_ff.pclass, 2'b00,
          ctrl_ff.resume_port_irq_enable, ctrl_ff.state_timeout_flag,
          ctrl_ff.cable_power_change_flag, ctrl_ff.config_timeout_flag,
          ctrl_ff.port_event_flag, ctrl_ff.link_control_bit};
        `PLON_STAT_OFS: nxt_prdata = {26'h0, tx_st_ff == PLON_TX_SHIFT,
          link_active, cause_ff, wake_ff};
        `PLON_IRQ_STAT_OFS: nxt_prdata = {29'h0, ist_ff};
        `PLON_IRQ_MASK_OFS: nxt_prdata = {29'h0, mask_ff};
        `PLON_TX_OFS: nxt_prdata = {{(32-TX_W){1'b0}}, tx_sh_ff};
        default: begin
          nxt_prdata = 32'h0000_0000;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
    // Hardware set wins over a software clear.
    if (any_cause == 1'b0 && |nxt_cause) nxt_ist[`PLON_IRQ_WAKE_ON] = 1'b1;
    if (any_cause && !(|nxt_cause)) nxt_ist[`PLON_IRQ_WAKE_OFF] = 1'b1;
    if (tx_done) nxt_ist[`PLON_IRQ_TX_DONE] = 1'b1;
    nxt_irq = |(nxt_ist & nxt_mask);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctrl_ff <= '0;
      cause_ff <= '0;
      pwr_cnt_ff <= 32'h0000_0000;
      wave_cnt_ff <= 3'h0;
      wake_ff <= 1'b0;
      oe_n_ff <= 1'b1; // [R4]
      ist_ff <= 3'h0;
      mask_ff <= `PLON_MASK_RST;
      irq_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      tx_st_ff <= PLON_TX_IDLE;
      tx_sh_ff <= '0;
      tx_cnt_ff <= '0;
      ser_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      cause_ff <= nxt_cause;
      pwr_cnt_ff <= nxt_pwr_cnt;
      wave_cnt_ff <= nxt_wave_cnt;
      wake_ff <= nxt_wake;
      oe_n_ff <= nxt_oe_n;
      ist_ff <= nxt_ist;
      mask_ff <= nxt_mask;
      irq_ff <= nxt_irq;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      tx_st_ff <= nxt_tx_st;
      tx_sh_ff <= nxt_tx_sh;
      tx_cnt_ff <= nxt_tx_cnt;
      ser_ff <= nxt_ser;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign phy_status_serial_out = ser_ff;
  assign link_wake_notify_out = wake_ff;
  assign link_wake_notify_oe_n = oe_n_ff;
  assign irq = irq_ff;

  // Checks on the wake output.
  sequence s_active4;
    wake_ff [*4];
  endsequence
  sequence s_low4;
    !wake_ff [*4];
  endsequence

  AST_WAVE_SHAPE: assert property (@(posedge sys_clk) // [R14]
    disable iff (reset || !any_cause)
    $rose(wake_ff) |-> s_active4 ##1 s_low4)
    else $error("wake phases not four cycles each");
  AST_PERIOD: assert property (@(posedge sys_clk) // [R3]
    disable iff (reset)
    ($rose(wake_ff) && any_cause) ##1 any_cause [*7] |=> wake_ff)
    else $error("wake period not eight cycles");
  AST_LOW_IDLE: assert property (@(posedge sys_clk) // [R4]
    disable iff (reset) !any_cause |=> !wake_ff)
    else $error("wake not low when inactive");
  AST_DRIVEN: assert property (@(posedge sys_clk) // [R2]
    $past(reset) && !reset |=> !oe_n_ff)
    else $error("wake pin not driven after reset");
  AST_OE_RESET: assert property (@(posedge sys_clk) // [R4]
    reset |=> oe_n_ff)
    else $error("wake pin driven during reset");
  // Checks on activation causes and the power timer.
  AST_NO_ACT_LINK: assert property (@(posedge sys_clk) // [R5] [R10]
    disable iff (reset) link_active |=> !any_cause)
    else $error("activation while link active");
  AST_PORT_EVENT: assert property (@(posedge sys_clk) // [R7]
    disable iff (reset)
    (ctrl_ff.port_event_flag && !link_active) |=> cause_ff.flag)
    else $error("port event did not activate");
  AST_RESUME_FLAGS: assert property (@(posedge sys_clk) // [R8] [R13]
    disable iff (reset)
    (ctrl_ff.resume_port_irq_enable && ctrl_ff.state_timeout_flag &&
     !link_active) |=> any_cause)
    else $error("resume flags did not activate");
  AST_PKT: assert property (@(posedge sys_clk) // [R6]
    disable iff (reset)
    (pkt_rise && !link_active && !any_cause) |=> cause_ff.pkt ##1 wake_ff)
    else $error("link-on packet did not activate");
  AST_BRST: assert property (@(posedge sys_clk) // [R11]
    disable iff (reset) (brst_rise && !pkt_rise) |=> !cause_ff.pkt)
    else $error("bus reset kept packet cause");
  AST_BRST_KEEP: assert property (@(posedge sys_clk) // [R11]
    disable iff (reset)
    (brst_rise && flag_cond && !link_active) |=> cause_ff.flag)
    else $error("bus reset dropped flag cause");
  AST_PWR: assert property (@(posedge sys_clk) // [R9]
    disable iff (reset)
    (pwr_rise && !link_active && ctrl_ff.pclass > `PLON_MAX_PCLASS
     && !cause_ff.pwr) |=> !cause_ff.pwr)
    else $error("power class out of range activated");
  AST_PWR_START: assert property (@(posedge sys_clk) // [R9]
    disable iff (reset)
    (pwr_rise && !link_active && ctrl_ff.pclass <= `PLON_MAX_PCLASS)
    |=> cause_ff.pwr)
    else $error("power cycle did not activate");
  AST_PWR_END: assert property (@(posedge sys_clk) // [R12]
    disable iff (reset)
    pwr_expire && !link_active && !pwr_rise |=> !cause_ff.pwr)
    else $error("power-cycle wake did not stop");
  // Checks on the serial shifter.
  AST_SER: assert property (@(posedge sys_clk) // [R1]
    disable iff (reset)
    (tx_st_ff == PLON_TX_SHIFT && tx_cnt_ff != '0) |=>
      ser_ff == $past(tx_sh_ff[TX_W-1]))
    else $error("serial bit mismatch");
  AST_SER_IDLE: assert property (@(posedge sys_clk) // [R1]
    disable iff (reset) (tx_st_ff == PLON_TX_IDLE) |=> !ser_ff)
    else $error("serial output not low when idle");
  AST_TX_DONE: assert property (@(posedge sys_clk) // [R1]
    disable iff (reset) tx_done |=> ist_ff[`PLON_IRQ_TX_DONE])
    else $error("serial done status not set");
endmodule
`default_nettype wire

// ### rtl/plon_defines.svh
`ifndef PLON_DEFINES_SVH
`define PLON_DEFINES_SVH
// Notes on behaviour
// [R1] Status words go out serially on phy_status_serial_out, one bit per clock, MSB first.
// [R2] After reset the shared terminal serves as the link wake notification output.
// [R3] While active the wake output is a square wave with a period of eight clocks.
// [R4] When inactive the wake output is driven low, and during reset it is not driven.
// [R5] Activation is allowed only while the link is inactive.
// [R6] A link-on packet addressed to this node activates the wake output.
// [R7] A set port event flag activates the wake output.
// [R8] Any of the three timeout or power flags activates it when the resume enable is set.
// [R9] A power cycle activates it when the power class is 0 through 4.
// [R10] Once active it stays active until the link becomes active; the flag cause drops when its flags are cleared.
// [R11] A bus reset ends activation that rests only on a received link-on packet.
// [R12] Activation from a power cycle stops after 167 ms if the link stays inactive.
// [R13] A flag condition present while the link is active activates once it goes inactive.
// [R14] The square wave is high for four clocks and then low for four.

// Register map for APB.
`define PLON_CTRL_OFS 12'h000
`define PLON_STAT_OFS 12'h004
`define PLON_IRQ_STAT_OFS 12'h008
`define PLON_IRQ_MASK_OFS 12'h00C
`define PLON_TX_OFS 12'h010
// Control bit positions.
`define PLON_CTRL_LINK_CTL 0
`define PLON_CTRL_PORT_EVT 1
`define PLON_CTRL_CFG_TMO 2
`define PLON_CTRL_CBL_PWR 3
`define PLON_CTRL_STATE_TMO 4
`define PLON_CTRL_RESUME_EN 5
`define PLON_CTRL_PCLS 8
// Interrupt bit positions.
`define PLON_IRQ_WAKE_ON 0
`define PLON_IRQ_WAKE_OFF 1
`define PLON_IRQ_TX_DONE 2
// Reset values.
`define PLON_CTRL_RST 32'h0000_0000
`define PLON_MASK_RST 3'h0
// Timing.
`define PLON_CLK_MHZ 50
`define PLON_WAVE_HALF 4
`define PLON_PWR_TMO_MS 167
`define PLON_PWR_TMO_CYC (`PLON_PWR_TMO_MS * 1000 * `PLON_CLK_MHZ)
`define PLON_MAX_PCLASS 3'h4
`endif

// ### rtl/plon_pkg.sv
`default_nettype none
package plon_pkg;
  typedef struct packed {
    logic link_control_bit;
    logic port_event_flag;
    logic config_timeout_flag;
    logic cable_power_change_flag;
    logic state_timeout_flag;
    logic resume_port_irq_enable;
    logic [2:0] pclass;
  } plon_ctrl_t;
  typedef struct packed {
    logic pkt;
    logic flag;
    logic pwr;
  } plon_cause_t;
  typedef enum logic [1:0] {PLON_TX_IDLE, PLON_TX_SHIFT} plon_tx_state_t;
endpackage
`default_nettype wire

// ### test/plon_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module plon_link_model (
  // Clock.
  input wire logic sys_clk,
  // Pins from the notifier.
  input wire logic phy_status_serial_out,
  // Pins to the notifier.
  output logic link_power_status_in,
  // Captured status word.
  output logic [15:0] rx_word
);
  int cnt = 0;
  initial link_power_status_in = 1'b0;
  // Collect one word whose first bit is a one, most significant first.
  always @(posedge sys_clk) begin
    if (cnt > 0 || phy_status_serial_out === 1'b1) begin
      rx_word <= {rx_word[14:0], phy_status_serial_out};
      cnt <= (cnt == 15) ? 0 : cnt + 1;
    end
  end
  // Drives the link power status pin.
  task set_link_power(input logic v);
    @(posedge sys_clk);
    link_power_status_in <= v;
  endtask
endmodule
`default_nettype wire

// ### test/plon_notifier_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "plon_defines.svh"
module plon_notifier_tb;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, link_pwr, ser, wake, oe_n, irq;
  logic [2:0] pin_v = 3'h0;
  logic [15:0] rx_word;
  int err_total = 0, n_compared = 0;
  plon_notifier #(.PWR_TMO_CYC(50), .TX_W(16)) dut (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_power_status_in(link_pwr),
    .link_on_pkt_in(pin_v[0]), .bus_reset_in(pin_v[1]),
    .power_cycled_in(pin_v[2]), .phy_status_serial_out(ser),
    .link_wake_notify_out(wake), .link_wake_notify_oe_n(oe_n), .irq(irq));
  plon_link_model lnk (.sys_clk(sys_clk), .phy_status_serial_out(ser),
    .link_power_status_in(link_pwr), .rx_word(rx_word));
  initial forever #10 sys_clk = ~sys_clk;
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task pulse(input int i);
    @(posedge sys_clk);
    pin_v[i] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pin_v[i] <= 1'b0;
  endtask
  // Looks for a rise, then checks four high and four low samples.
  task wake_chk(input logic e);
    logic seen;
    logic prev;
    seen = 0;
    @(negedge sys_clk);
    prev = wake;
    for (int k = 0; k < 24 && !seen; k++) begin
      @(negedge sys_clk);
      seen = e ? (wake === 1'b1 && prev === 1'b0) : (wake !== 1'b0);
      prev = wake;
    end
    chk("wake_active", e, seen);
    for (int i = 1; i < 8 && seen && e; i++) begin
      @(negedge sys_clk);
      chk("wake_shape", i < 4, wake);
    end
  endtask
  task ctrl(input logic [31:0] v);
    apb(1, `PLON_CTRL_OFS, v);
    repeat (10) @(posedge sys_clk);
  endtask
  task t_reset;
    @(negedge sys_clk);
    chk("oe_n_in_reset", 1, oe_n);
    @(posedge sys_clk);
    reset <= 0;
    repeat (2) @(negedge sys_clk);
    chk("oe_n_after", 0, oe_n);
    chk("wake_idle", 0, wake);
    $display("test reset done");
  endtask
  task t_flags;
    ctrl(32'h0000_0002);
    wake_chk(1);
    for (int f = 2; f < 5; f++) begin
      ctrl(32'h0000_0000);
      wake_chk(0);
      ctrl(32'h0000_0020 | (32'h1 << f));
      wake_chk(1);
    end
    ctrl(32'h0000_0008);
    wake_chk(0);
    $display("test flags done");
  endtask
  task t_pkt;
    ctrl(32'h0000_0000);
    pulse(0);
    wake_chk(1);
    pulse(1);
    repeat (6) @(posedge sys_clk);
    wake_chk(0);
    pulse(0);
    ctrl(32'h0000_0002);
    pulse(1);
    wake_chk(1);
    lnk.set_link_power(1);
    ctrl(32'h0000_0003);
    wake_chk(0);
    pulse(0);
    wake_chk(0);
    ctrl(32'h0000_0002);
    wake_chk(1);
    lnk.set_link_power(0);
    ctrl(32'h0000_0000);
    $display("test packet done");
  endtask
  task t_pwr;
    ctrl(32'h0000_0500);
    pulse(2);
    wake_chk(0);
    ctrl(32'h0000_0400);
    pulse(2);
    wake_chk(1);
    repeat (60) @(posedge sys_clk);
    wake_chk(0);
    $display("test power done");
  endtask
  task t_tx;
    apb(1, `PLON_IRQ_MASK_OFS, 32'h0000_0004);
    apb(1, `PLON_IRQ_STAT_OFS, 32'h0000_0007);
    apb(1, `PLON_TX_OFS, 32'h0000_A5C3);
    apb(1, `PLON_TX_OFS, 32'h0000_0001);
    chk("tx_busy_err", 1, err);
    repeat (24) @(posedge sys_clk);
    chk("rx_word", 32'h0000_A5C3, rx_word);
    chk("irq_done", 1, irq);
    apb(1, `PLON_IRQ_STAT_OFS, 32'h0000_0004);
    @(negedge sys_clk);
    chk("irq_clear", 0, irq);
    apb(0, 12'h020, 32'h0000_0000);
    chk("unmapped_err", 1, err);
    chk("unmapped_data", 0, rd);
    apb(1, `PLON_CTRL_OFS, 32'h0000_043D);
    apb(0, `PLON_CTRL_OFS, 32'h0000_0000);
    chk("ctrl_readback", 32'h0000_043D, rd);
    $display("test serial done");
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    t_reset;
    t_flags;
    t_pkt;
    t_pwr;
    t_tx;
    results;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    results;
  end
endmodule
`default_nettype wire
